/* logic/chan_cfg_pkg.sv */
/*
 contents: constants and types for the output channel configuration bank.
 assumes:  used with package-scoped names only, never imported.
*/
package chan_cfg_pkg;
   // ---------------------------------------------------------------
   // register map (printed offsets are not multiples of four)
   // ---------------------------------------------------------------
   localparam logic [7:0]  CH4_DIV_INDEX   = 8'h26;
   localparam logic [7:0]  CH5_CTL_INDEX   = 8'h27;
   localparam logic [11:0] CH4_DIV_ADDR    = 12'h098;  // index times four
   localparam logic [11:0] CH5_CTL_ADDR    = 12'h09c;
   localparam logic [11:0] CH5_STAT_ADDR   = 12'h0a0;  // decoded channel 5 state
   localparam int          ADDR_W          = 12;

   // ---------------------------------------------------------------
   // reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0]  CH4_DIV_RESET   = 8'h02;
   localparam logic [7:0]  CH5_CTL_RESET   = 8'h18;    // source 0, fmt 1, a 2, b 0
   localparam int          SRC_LSB         = 6;
   localparam int          FMT_LSB         = 4;
   localparam int          MODE_A_LSB      = 2;
   localparam int          MODE_B_LSB      = 0;

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ---------------------------------------------------------------
   // field encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_SYNTH1    = 2'h0,
      SRC_SYNTH2    = 2'h1,
      SRC_PRI_REF   = 2'h2,
      SRC_SEC_REF   = 2'h3
   } source_type;

   typedef enum logic [1:0] {
      FMT_OFF       = 2'h0,
      FMT_AC_DIFF   = 2'h1,
      FMT_HCSL      = 2'h2,
      FMT_CMOS      = 2'h3
   } format_type;

   typedef enum logic [1:0] {
      PIN_TRISTATE  = 2'h0,
      PIN_LOW       = 2'h1,
      PIN_INVERTED  = 2'h2,
      PIN_TRUE      = 2'h3
   } cmos_pin_type;
endpackage

/* logic/chan_cfg_if.sv */
/*
 contents: carrier for one channel's decoded divider setting.
 assumes:  driven by the divider decode, read by the bank top.
*/
`timescale 1ns/1ps
interface chan_cfg_if;
   logic [7:0] div_value;   // raw field
   logic       div_active;  // divider in the path
   logic [8:0] div_ratio;   // effective ratio, 1 when bypassed
   modport decode (input div_value, output div_active, output div_ratio);
   modport user   (output div_value, input div_active, input div_ratio);
endinterface

/* logic/div_decode.sv */
/*
 contents: output divider decode, instantiated for channel 4 only.
 assumes:  synth_src says the channel is fed from a synthesizer.
*/
`timescale 1ns/1ps
module div_decode (
   // decode side
   chan_cfg_if.decode       cfg,
   // source qualifier
   input  wire logic        synth_src
);
   // zero bypasses; n divides by n plus one; references always bypass
   always_comb begin
      cfg.div_active = synth_src && (cfg.div_value != 8'h00);
      if (cfg.div_active) begin
         cfg.div_ratio = {1'b0, cfg.div_value} + 9'h001;
      end else begin
         cfg.div_ratio = 9'h001;
      end
   end
endmodule

/* logic/output_channel_config_regs.sv */
/*
 contents: configuration bank for output channels 4 and 5 with an
           AXI4-Lite slave, source mux, divider and driver decode.
 assumes:  one clock, synchronous active-high reset, channel 4 source
           select arrives from outside this bank.
*/
// Overview of operation
// - channel 4 divider is 8 bits; zero bypasses, n divides by n+1.
// - output divider acts only when source is a synthesizer output.
// - channel 5 source code: synth1, synth2, primary ref, secondary ref.
// - with doubler on, channel 5 reference sources raise ch5_ref_doubled; ch5_src_clk carries the undoubled reference.
// - channel 5 divider bypassed when either reference is the source.
// - channel 5 format: off, AC differential, HCSL, CMOS.
// - mode A gives tail current in differential, positive pin in CMOS.
// - mode B gives HCSL load, or negative pin in CMOS.
`timescale 1ns/1ps
module output_channel_config_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // axi4-lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   // axi4-lite write response
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   // axi4-lite read data
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // clock sources and channel 4 source
   input  wire logic        synth1_clk,
   input  wire logic        synth2_clk,
   input  wire logic        pri_ref_clk,
   input  wire logic        sec_ref_clk,
   input  wire logic        doubler_en,
   input  wire logic [1:0]  ch4_source_select,
   // channel 4 divider outputs
   output      logic        ch4_div_active,
   output      logic [8:0]  ch4_div_ratio,
   // channel 5 mux and buffer outputs
   output      logic        ch5_src_clk,
   output      logic        ch5_ref_doubled,
   output      logic        ch5_div_bypass,
   output      logic        ch5_enable,
   output      logic [1:0]  ch5_format,
   output      logic [4:0]  ch5_tail_ma,
   output      logic [7:0]  ch5_load_ohm,
   output      logic [1:0]  ch5_pos_pin,
   output      logic [1:0]  ch5_neg_pin
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0]  ch4_div_reg;
   logic [7:0]  ch5_ctl_reg;
   logic [11:0] aw_addr_reg;
   logic        aw_held_reg;
   logic [31:0] w_data_reg;
   logic        w_strb0_reg;
   logic        w_held_reg;

   logic [1:0]  ch5_source_select;
   logic [1:0]  ch5_drive_mode_a;
   logic [1:0]  ch5_drive_mode_b;
   logic        ch4_synth_src;
   logic        ch5_synth_src;
   logic        do_write;
   logic        aw_hit;
   logic        ar_ok;
   logic [31:0] rd_word;

   assign ch5_source_select = ch5_ctl_reg[chan_cfg_pkg::SRC_LSB +: 2];
   assign ch5_format        = ch5_ctl_reg[chan_cfg_pkg::FMT_LSB +: 2];
   assign ch5_drive_mode_a  = ch5_ctl_reg[chan_cfg_pkg::MODE_A_LSB +: 2];
   assign ch5_drive_mode_b  = ch5_ctl_reg[chan_cfg_pkg::MODE_B_LSB +: 2];

   // ---------------------------------------------------------------
   // write channel: address and data taken in either order
   // ---------------------------------------------------------------
   // a held half stalls its own channel until the response is taken
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_strb0_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg  <= 1'b1;
         w_data_reg  <= s_axi_wdata;
         w_strb0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   assign aw_hit = (aw_addr_reg == chan_cfg_pkg::CH4_DIV_ADDR) ||
                   (aw_addr_reg == chan_cfg_pkg::CH5_CTL_ADDR) ||
                   (aw_addr_reg == chan_cfg_pkg::CH5_STAT_ADDR);

   // response one cycle after both halves are present
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= chan_cfg_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= aw_hit ? chan_cfg_pkg::RESP_OKAY : chan_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   // only byte lane 0 carries data; the status word is read-only
   always_ff @(posedge clk) begin
      if (rst) begin
         ch4_div_reg <= chan_cfg_pkg::CH4_DIV_RESET;
         ch5_ctl_reg <= chan_cfg_pkg::CH5_CTL_RESET;
      end else if (do_write && w_strb0_reg) begin
         if (aw_addr_reg == chan_cfg_pkg::CH4_DIV_ADDR) begin
            ch4_div_reg <= w_data_reg[7:0];
         end
         if (aw_addr_reg == chan_cfg_pkg::CH5_CTL_ADDR) begin
            ch5_ctl_reg <= w_data_reg[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_ok = (s_axi_araddr == chan_cfg_pkg::CH4_DIV_ADDR) ||
                  (s_axi_araddr == chan_cfg_pkg::CH5_CTL_ADDR) ||
                  (s_axi_araddr == chan_cfg_pkg::CH5_STAT_ADDR);

   // status word shows the live decode of channel 5
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         chan_cfg_pkg::CH4_DIV_ADDR:  rd_word[7:0] = ch4_div_reg;
         chan_cfg_pkg::CH5_CTL_ADDR:  rd_word[7:0] = ch5_ctl_reg;
         chan_cfg_pkg::CH5_STAT_ADDR: rd_word[7:0] = {ch5_enable, ch5_div_bypass,
                                                      ch5_ref_doubled, ch5_tail_ma};
         default:                     rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= chan_cfg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= ar_ok ? chan_cfg_pkg::RESP_OKAY : chan_cfg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // channel 4 divider
   // ---------------------------------------------------------------
   chan_cfg_if ch4_cfg ();
   assign ch4_cfg.div_value = ch4_div_reg;
   assign ch4_synth_src     = !ch4_source_select[1];

   div_decode ch4_div (
      .cfg       (ch4_cfg.decode),
      .synth_src (ch4_synth_src)
   );

   assign ch4_div_active = ch4_cfg.div_active;
   assign ch4_div_ratio  = ch4_cfg.div_ratio;

   // ---------------------------------------------------------------
   // channel 5 source mux
   // ---------------------------------------------------------------
   // a pure mux; clock glitches on a live switch are the buffer's concern
   always_comb begin
      case (ch5_source_select)
         chan_cfg_pkg::SRC_SYNTH1:  ch5_src_clk = synth1_clk;
         chan_cfg_pkg::SRC_SYNTH2:  ch5_src_clk = synth2_clk;
         chan_cfg_pkg::SRC_PRI_REF: ch5_src_clk = pri_ref_clk;
         chan_cfg_pkg::SRC_SEC_REF: ch5_src_clk = sec_ref_clk;
         default:                   ch5_src_clk = synth1_clk;
      endcase
   end

   assign ch5_synth_src   = !ch5_source_select[1];
   assign ch5_ref_doubled = doubler_en && !ch5_synth_src;
   assign ch5_div_bypass  = !ch5_synth_src;

   // ---------------------------------------------------------------
   // channel 5 driver decode
   // ---------------------------------------------------------------
   assign ch5_enable = (ch5_format != chan_cfg_pkg::FMT_OFF);

   // tail current in mA; zero outside differential formats
   always_comb begin
      ch5_tail_ma = 5'h00;
      if (ch5_format == chan_cfg_pkg::FMT_AC_DIFF ||
          ch5_format == chan_cfg_pkg::FMT_HCSL) begin
         case (ch5_drive_mode_a)
            2'h0:    ch5_tail_ma = 5'h04;
            2'h1:    ch5_tail_ma = 5'h06;
            2'h2:    ch5_tail_ma = 5'h08;
            2'h3:    ch5_tail_ma = (ch5_format == chan_cfg_pkg::FMT_HCSL) ? 5'h10 : 5'h08;
            default: ch5_tail_ma = 5'h00;
         endcase
      end
   end

   // hcsl load in ohm; zero means tristate or not hcsl
   always_comb begin
      ch5_load_ohm = 8'h00;
      if (ch5_format == chan_cfg_pkg::FMT_HCSL) begin
         case (ch5_drive_mode_b)
            2'h1:    ch5_load_ohm = 8'h32;
            2'h2:    ch5_load_ohm = 8'h64;
            2'h3:    ch5_load_ohm = 8'hc8;
            default: ch5_load_ohm = 8'h00;
         endcase
      end
   end

   // cmos pins; tristate whenever the format is not cmos
   assign ch5_pos_pin = (ch5_format == chan_cfg_pkg::FMT_CMOS) ?
                        ch5_drive_mode_a : chan_cfg_pkg::PIN_TRISTATE;
   assign ch5_neg_pin = (ch5_format == chan_cfg_pkg::FMT_CMOS) ?
                        ch5_drive_mode_b : chan_cfg_pkg::PIN_TRISTATE;
endmodule

/* tb/output_channel_config_regs_assertions.sv */
/*
 contents: concurrent checks on the channel 4/5 configuration bank ports.
 assumes:  bound to every instance of the bank, one clock, sync reset.
*/
`timescale 1ns/1ps
module chan_cfg_checker (
   // clock, reset and bus handshakes
   input wire logic        clk, rst, s_axi_bvalid, s_axi_bready,
   input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [1:0]  s_axi_bresp, ch4_source_select, ch5_format,
   input wire logic [31:0] s_axi_rdata,
   // decoded channel outputs
   input wire logic        doubler_en, ch4_div_active, ch5_ref_doubled, ch5_div_bypass,
   input wire logic        ch5_enable,
   input wire logic [1:0]  ch5_pos_pin, ch5_neg_pin,
   input wire logic [8:0]  ch4_div_ratio,
   input wire logic [4:0]  ch5_tail_ma,
   input wire logic [7:0]  ch5_load_ohm
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // decode relations
   // ------------------------------------------------------------
   property p_ratio; !ch4_div_active |-> ch4_div_ratio == 9'h001; endproperty
   a_ratio: assert property (p_ratio) else $error("ratio not one when bypassed");
   property p_active;
      ch4_div_active |-> !ch4_source_select[1] && ch4_div_ratio > 9'h001;
   endproperty
   a_active: assert property (p_active) else $error("divider active on ref");
   property p_double; ch5_ref_doubled == (doubler_en && ch5_div_bypass); endproperty
   a_double: assert property (p_double) else $error("doubled flag wrong");
   property p_enable; ch5_enable == (ch5_format != 2'h0); endproperty
   a_enable: assert property (p_enable) else $error("enable disagrees with format");
   property p_pins;
      ch5_format != 2'h3 |-> ch5_pos_pin == 2'h0 && ch5_neg_pin == 2'h0;
   endproperty
   a_pins: assert property (p_pins) else $error("cmos pins driven off cmos");
   property p_load; ch5_format != 2'h2 |-> ch5_load_ohm == 8'h00; endproperty
   a_load: assert property (p_load) else $error("load set outside hcsl");
   property p_tail; ch5_format == 2'h1 |-> ch5_tail_ma inside {5'h04, 5'h06, 5'h08}; endproperty
   a_tail: assert property (p_tail) else $error("ac tail current out of set");
   // ------------------------------------------------------------
   // bus answers hold until taken; read answer one cycle after acceptance
   // ------------------------------------------------------------
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped early");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped early");
   c_cmos: cover property (ch5_format == 2'h3 && ch5_pos_pin == 2'h3);
   c_bypass: cover property (ch5_ref_doubled);
   c_div: cover property (ch4_div_active && ch4_div_ratio == 9'h100);
endmodule
bind output_channel_config_regs chan_cfg_checker chk (.clk, .rst, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
   .ch4_source_select, .ch5_format, .s_axi_rdata, .doubler_en, .ch4_div_active,
   .ch5_ref_doubled, .ch5_div_bypass, .ch5_enable, .ch5_pos_pin, .ch5_neg_pin,
   .ch4_div_ratio, .ch5_tail_ma, .ch5_load_ohm);

/* tb/test_output_channel_config_regs.sv */
/*
 contents: self-checking bench for the channel 4/5 configuration bank.
 assumes:  checker bound separately; bus answers compared from queues.
*/
`timescale 1ns/1ps
module test_output_channel_config_regs;
   logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, dbl = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, srcs = 4'h0;
   logic [1:0] sel4 = 2'h0, bresp, rresp, fmt, pos, neg;
   logic [8:0] ratio;
   logic [4:0] tail;
   logic [7:0] load, c, dv [5];
   logic act, sclk, rdbl, byp, en;
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   int bad_count = 0, check_count = 0, cyc = 0;
   logic [31:0] r;
   output_channel_config_regs uut (.clk, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .synth1_clk(srcs[0]), .synth2_clk(srcs[1]), .pri_ref_clk(srcs[2]), .sec_ref_clk(srcs[3]),
      .doubler_en(dbl), .ch4_source_select(sel4), .ch4_div_active(act), .ch4_div_ratio(ratio),
      .ch5_src_clk(sclk), .ch5_ref_doubled(rdbl), .ch5_div_bypass(byp), .ch5_enable(en),
      .ch5_format(fmt), .ch5_tail_ma(tail), .ch5_load_ohm(load), .ch5_pos_pin(pos),
      .ch5_neg_pin(neg));
   initial forever #50 clk = ~clk;
   // ------------------------------------------------------------
   // comparison, verdict and hang guard
   // ------------------------------------------------------------
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // oldest note is consumed at each completed answer
   always @(posedge clk) begin
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) chk(bresp, bq.pop_front());
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // bus tasks: ready raised only after the answer shows, to stall it
   // ------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic ha, hw, v;
      bq.push_back(er);
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
         @(negedge clk);
         ha = awvalid && awready; hw = wvalid && wready; v = bvalid;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end while (!v);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
      logic h, v;
      rq.push_back({er, ed});
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1;
      do begin
         @(negedge clk);
         h = arvalid && arready; v = rvalid;
         @(posedge clk);
         if (h) arvalid <= 1'b0;
      end while (!v);
      rready <= 1'b1;
      @(posedge clk);
      rready <= 1'b0;
   endtask
   // expected status word and channel 5 decode for control value x
   function automatic logic [31:0] stat(input logic [7:0] x, input logic d);
      logic [4:0] t;
      t = (x[5:4] == 2'h1 || x[5:4] == 2'h2) ? (x[3:2] == 2'h0 ? 5'h04 : x[3:2] == 2'h1 ?
          5'h06 : (x[3:2] == 2'h2 || x[5:4] == 2'h1) ? 5'h08 : 5'h10) : 5'h00;
      return {24'h0, x[5:4] != 2'h0, x[7], d && x[7], t};
   endfunction
   task automatic dchk(input logic [7:0] x);
      @(negedge clk);
      chk(sclk, srcs[x[7:6]]);
      chk({en, byp, rdbl, tail}, stat(x, dbl));
      chk(fmt, x[5:4]);
      chk(load, x[5:4] == 2'h2 && x[1:0] != 2'h0 ? 8'h19 << x[1:0] : 8'h00);
      chk({pos, neg}, x[5:4] == 2'h3 ? x[3:0] : 4'h0);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      r = $urandom(32'h90c9);
      dv = '{8'h00, 8'h01, 8'h02, 8'hff, 8'h80};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(chan_cfg_pkg::CH4_DIV_ADDR, chan_cfg_pkg::RESP_OKAY, 32'h02);
      rd(chan_cfg_pkg::CH5_CTL_ADDR, chan_cfg_pkg::RESP_OKAY, 32'h18);
      dchk(8'h18);
      foreach (dv[i]) for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         sel4 <= s[1:0];
         r = $urandom;
         wr(chan_cfg_pkg::CH4_DIV_ADDR, {r[31:8], dv[i]}, 4'hf, chan_cfg_pkg::RESP_OKAY);
         rd(chan_cfg_pkg::CH4_DIV_ADDR, chan_cfg_pkg::RESP_OKAY, {24'h0, dv[i]});
         chk(act, dv[i] != 8'h00 && s < 2);
         chk(ratio, (dv[i] != 8'h00 && s < 2) ? {1'b0, dv[i]} + 9'h001 : 9'h001);
      end
      for (int i = 0; i < 256; i++) begin
         c = i[7:0];
         r = $urandom;
         @(posedge clk);
         srcs <= r[3:0]; dbl <= r[4];
         wr(chan_cfg_pkg::CH5_CTL_ADDR, {r[31:8], c}, 4'hf, chan_cfg_pkg::RESP_OKAY);
         rd(chan_cfg_pkg::CH5_CTL_ADDR, chan_cfg_pkg::RESP_OKAY, {24'h0, c});
         rd(chan_cfg_pkg::CH5_STAT_ADDR, chan_cfg_pkg::RESP_OKAY, stat(c, r[4]));
         dchk(c);
      end
      // refused and ignored accesses leave the control value alone
      wr(12'h0a4, 32'h77, 4'hf, chan_cfg_pkg::RESP_SLVERR);
      rd(12'h0a4, chan_cfg_pkg::RESP_SLVERR, 32'h0);
      wr(chan_cfg_pkg::CH5_CTL_ADDR, 32'h55, 4'he, chan_cfg_pkg::RESP_OKAY);
      wr(chan_cfg_pkg::CH5_STAT_ADDR, 32'h55, 4'hf, chan_cfg_pkg::RESP_OKAY);
      rd(chan_cfg_pkg::CH5_CTL_ADDR, chan_cfg_pkg::RESP_OKAY, 32'hff);
      // second reset restores the documented values
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(chan_cfg_pkg::CH4_DIV_ADDR, chan_cfg_pkg::RESP_OKAY, 32'h02);
      rd(chan_cfg_pkg::CH5_CTL_ADDR, chan_cfg_pkg::RESP_OKAY, 32'h18);
      dchk(8'h18);
      repeat (2) @(posedge clk);
      end_of_test();
   end
endmodule
